// *** acc_defs.vh ***
// register map, field positions and reset values of the amp/comparator unit
`ifndef ACC_DEFS_VH
`define ACC_DEFS_VH
`define ACC_ADDR_W          4
`define ACC_OFS_GLOBAL_MODE 4'h0
`define ACC_OFS_CH0_CTL     4'h4
`define ACC_OFS_CH1_CTL     4'h8
`define ACC_BIT_GLOBAL_EN   0
`define ACC_BIT_CMP_MODE    1
`define ACC_BIT_CIRC_EN     0
`define ACC_BIT_OUT_EN      6
`define ACC_BIT_RESULT      11
`define ACC_REG_RESET       16'h0000
`define ACC_NUM_CH          2
`endif

// *** acc_sync.v ***
// two-flop synchroniser for one asynchronous level per channel
`default_nettype none
module acc_sync #(
   parameter W = 2
) (
   input  wire         clk,
   input  wire         rst,
   input  wire [W-1:0] din,
   output reg  [W-1:0] dout
);
   reg [W-1:0] stage1;

   always @(posedge clk) begin
      if (rst) begin
         stage1 <= {W{1'b0}};
         dout   <= {W{1'b0}};
      end else begin
         stage1 <= din;
         dout   <= stage1;
      end
   end
endmodule
`default_nettype wire

// *** acc_amp_comparator_unit.v ***
// register bank and enable logic of the amplifier/comparator unit
//
// The Avalon-MM register port and the address map were decided locally.
`default_nettype none
`include "acc_defs.vh"
module acc_amp_comparator_unit #(
   parameter NUM_CH = `ACC_NUM_CH
) (
   input  wire                   CLK_SYS,
   input  wire                   RST,
   input  wire [`ACC_ADDR_W-1:0] AVS_ADDRESS,
   input  wire                   AVS_READ,
   input  wire                   AVS_WRITE,
   input  wire [31:0]            AVS_WRITEDATA,
   input  wire [3:0]             AVS_BYTEENABLE,
   output reg  [31:0]            AVS_READDATA,
   output reg                    AVS_WAITREQUEST,
   output reg  [1:0]             AVS_RESPONSE,
   input  wire [NUM_CH-1:0]      CMP_RAW,
   output reg  [NUM_CH-1:0]      CHANNEL_ACTIVE,
   output reg  [NUM_CH-1:0]      AMP_OUTPUT_DRIVE,
   output reg                    COMPARATOR_ACTIVE
);
   reg                global_operation_enable;
   reg                comparator_mode_select;
   reg [NUM_CH-1:0]   channel_circuit_enable;
   reg [NUM_CH-1:0]   amp_output_enable;
   reg [NUM_CH-1:0]   comparison_result;
   wire [NUM_CH-1:0]  cmp_sync;
   reg                answered;
   reg [15:0]         next_rdata;
   reg                hit;
   integer            i;

   // comparator output is analog-timed, so it is synchronised first
   acc_sync #(.W(NUM_CH)) u_sync (
      .clk  (CLK_SYS),
      .rst  (RST),
      .din  (CMP_RAW),
      .dout (cmp_sync)
   );

   // returns the channel index selected by an address, or NUM_CH if none
   function integer ch_index;
      input [`ACC_ADDR_W-1:0] a;
      begin
         ch_index = NUM_CH;
         if (a == `ACC_OFS_CH0_CTL)
            ch_index = 0;
         else if (a == `ACC_OFS_CH1_CTL && NUM_CH > 1)
            ch_index = 1;
      end
   endfunction

   wire req   = (AVS_READ | AVS_WRITE) & ~answered;
   wire low_w = AVS_WRITE & AVS_BYTEENABLE[0];

   // read mux; reserved bits stay zero
   always @* begin
      next_rdata = 16'h0000;
      hit = 1'b0;
      if (AVS_ADDRESS == `ACC_OFS_GLOBAL_MODE) begin
         hit = 1'b1;
         next_rdata[`ACC_BIT_GLOBAL_EN] = global_operation_enable;
         next_rdata[`ACC_BIT_CMP_MODE]  = comparator_mode_select;
      end else if (ch_index(AVS_ADDRESS) < NUM_CH) begin
         hit = 1'b1;
         next_rdata[`ACC_BIT_CIRC_EN] =
            channel_circuit_enable[ch_index(AVS_ADDRESS)];
         next_rdata[`ACC_BIT_OUT_EN] =
            amp_output_enable[ch_index(AVS_ADDRESS)];
         next_rdata[`ACC_BIT_RESULT] =
            comparison_result[ch_index(AVS_ADDRESS)];
      end
   end

   // one wait cycle: waitrequest drops the cycle after a request appears
   always @(posedge CLK_SYS) begin
      if (RST) begin
         AVS_WAITREQUEST <= 1'b1;
         AVS_READDATA    <= 32'h0000_0000;
         AVS_RESPONSE    <= 2'h0;
         answered        <= 1'b0;
      end else begin
         answered        <= req;
         AVS_WAITREQUEST <= ~req;
         if (req) begin
            AVS_READDATA <= AVS_READ ? {16'h0000, next_rdata}
                                     : 32'h0000_0000;
            // unmapped address answers with slave error
            AVS_RESPONSE <= hit ? 2'h0 : 2'h2;
         end
      end
   end

   // register writes; only the low byte holds writable bits
   always @(posedge CLK_SYS) begin
      if (RST) begin
         global_operation_enable <= 1'b0;
         comparator_mode_select  <= 1'b0;
         channel_circuit_enable  <= {NUM_CH{1'b0}};
         amp_output_enable       <= {NUM_CH{1'b0}};
      end else if (req && low_w) begin
         if (AVS_ADDRESS == `ACC_OFS_GLOBAL_MODE) begin
            global_operation_enable <=
               AVS_WRITEDATA[`ACC_BIT_GLOBAL_EN];
            comparator_mode_select  <=
               AVS_WRITEDATA[`ACC_BIT_CMP_MODE];
         end
         for (i = 0; i < NUM_CH; i = i + 1) begin
            if (ch_index(AVS_ADDRESS) == i) begin
               channel_circuit_enable[i] <=
                  AVS_WRITEDATA[`ACC_BIT_CIRC_EN];
               amp_output_enable[i] <=
                  AVS_WRITEDATA[`ACC_BIT_OUT_EN];
            end
         end
      end
   end

   // analog-side controls, one flop each per channel
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g = g + 1) begin : g_ch
         always @(posedge CLK_SYS) begin
            if (RST) begin
               CHANNEL_ACTIVE[g]    <= 1'b0;
               AMP_OUTPUT_DRIVE[g]  <= 1'b0;
               comparison_result[g] <= 1'b0;
            end else begin
               CHANNEL_ACTIVE[g] <= global_operation_enable &
                                    channel_circuit_enable[g];
               // output driven whenever the channel is active and out-enabled, in amplifier or comparator use
               AMP_OUTPUT_DRIVE[g] <= global_operation_enable &
                                      channel_circuit_enable[g] &
                                      amp_output_enable[g];
               comparison_result[g] <= global_operation_enable &
                                       comparator_mode_select &
                                       channel_circuit_enable[g] &
                                       cmp_sync[g];
            end
         end
      end
   endgenerate

   always @(posedge CLK_SYS) begin
      if (RST)
         COMPARATOR_ACTIVE <= 1'b0;
      else
         COMPARATOR_ACTIVE <= global_operation_enable &
                              comparator_mode_select;
   end
endmodule
`default_nettype wire

// *** acc_asserts.sv ***
// port-level checker for the amp/comparator unit
`default_nettype none
module acc_asserts #(
   parameter NUM_CH = 2
) (
   input wire logic              CLK_SYS,
   input wire logic              RST,
   input wire logic              AVS_READ,
   input wire logic              AVS_WRITE,
   input wire logic [31:0]       AVS_READDATA,
   input wire logic              AVS_WAITREQUEST,
   input wire logic [1:0]        AVS_RESPONSE,
   input wire logic [NUM_CH-1:0] CHANNEL_ACTIVE,
   input wire logic [NUM_CH-1:0] AMP_OUTPUT_DRIVE,
   input wire logic              COMPARATOR_ACTIVE
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   wire rd_ans = AVS_READ && !AVS_WAITREQUEST;
   property p_ans; (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
      |-> ##[1:2] !AVS_WAITREQUEST; endproperty
   a_ans: assert property (p_ans) else $error("no answer");
   property p_ge; $fell(COMPARATOR_ACTIVE) |-> $past(AVS_WRITE, 2);
   endproperty
   a_ge: assert property (p_ge) else $error("mode fell alone");
   property p_cm; $rose(COMPARATOR_ACTIVE) |-> $past(AVS_WRITE, 2);
   endproperty
   a_cm: assert property (p_cm) else $error("mode rose alone");
   property p_oe; (AMP_OUTPUT_DRIVE & ~CHANNEL_ACTIVE) == '0; endproperty
   a_oe: assert property (p_oe) else $error("drive w/o active");
   property p_ce; $changed(CHANNEL_ACTIVE) |-> $past(AVS_WRITE, 2);
   endproperty
   a_ce: assert property (p_ce) else $error("active moved alone");
   property p_rsv; rd_ans |-> (AVS_READDATA & 32'hffff_f7bc) == 0;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bit set");
   property p_err; rd_ans && AVS_RESPONSE == 2'b10 |-> AVS_READDATA == 0;
   endproperty
   a_err: assert property (p_err) else $error("bad read data");
   property p_res; rd_ans && !COMPARATOR_ACTIVE |-> !AVS_READDATA[11];
   endproperty
   a_res: assert property (p_res) else $error("result leaks");
endmodule
bind acc_amp_comparator_unit acc_asserts #(.NUM_CH(NUM_CH)) chk_u (
   .CLK_SYS(CLK_SYS), .RST(RST), .AVS_READ(AVS_READ),
   .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
   .AVS_WAITREQUEST(AVS_WAITREQUEST), .AVS_RESPONSE(AVS_RESPONSE),
   .CHANNEL_ACTIVE(CHANNEL_ACTIVE), .AMP_OUTPUT_DRIVE(AMP_OUTPUT_DRIVE),
   .COMPARATOR_ACTIVE(COMPARATOR_ACTIVE));
`default_nettype wire

// *** acc_core_model.sv ***
// behavioural analog core, one comparator per channel
`default_nettype none
module acc_core_model (
   input wire logic        clk,
   input wire logic [1:0]  act,
   input wire logic [15:0] lvl_p,
   input wire logic [15:0] lvl_n,
   output var logic [1:0]  raw
);
   timeunit 1ns;
   timeprecision 1ps;
   logic tgl = 1'b0;
   // idle channel output wanders so the gating is exercised
   always @(posedge clk) begin
      tgl <= ~tgl;
      for (int i = 0; i < 2; i++)
         raw[i] <= act[i] ? lvl_p[i*8+:8] > lvl_n[i*8+:8] : tgl;
   end
endmodule
`default_nettype wire

// *** acc_tb.sv ***
// self-checking bench for the amp/comparator unit
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, rd = 0, wr = 0, wq, cact;
   logic [3:0] adr = 4'h0, be = 4'hf;
   logic [31:0] wd = 32'h0000_0000, rdat;
   logic [15:0] lp = 16'h0000, ln = 16'h0000;
   logic [1:0] rsp, raw, act, drv;
   int n_errors = 0, checks = 0;
   always #5 clk = ~clk;
   acc_amp_comparator_unit dut_u (.CLK_SYS(clk), .RST(rst),
      .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd),
      .AVS_BYTEENABLE(be), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wq),
      .AVS_RESPONSE(rsp), .CMP_RAW(raw), .CHANNEL_ACTIVE(act),
      .AMP_OUTPUT_DRIVE(drv), .COMPARATOR_ACTIVE(cact));
   acc_core_model core_u (.clk(clk), .act(act), .lvl_p(lp), .lvl_n(ln),
      .raw(raw));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic bus(input bit w, input logic [3:0] a,
                      input logic [15:0] d, input logic [15:0] e);
      @(posedge clk);
      adr <= a; wr <= w; rd <= !w; wd <= {16'h0000, d};
      // no cycle limit here: only the watchdog may end a stuck wait
      do @(posedge clk); while (wq !== 1'b0);
      rd <= 0; wr <= 0;
      if (!w) chk(rdat, {16'h0000, e});
      if (!w) chk({30'h0, rsp}, {30'h0, a > 4'h8 ? 2'b10 : 2'b00});
   endtask
   task automatic outs(input logic [4:0] e);
      repeat (2) @(posedge clk);
      chk({27'h0, cact, drv, act}, {27'h0, e});
   endtask
   task automatic t_reset;
      for (int i = 0; i < 16; i += 4) bus(0, i[3:0], 0, 0);
      $display("t_reset done");
   endtask
   task automatic t_amp;
      bus(1, 4'h0, 16'h0001, 0);
      be <= 4'h0;
      bus(1, 4'h4, 16'h0041, 0);
      be <= 4'hf;
      bus(0, 4'h4, 0, 16'h0000);
      bus(1, 4'h4, 16'hffff, 0);
      bus(0, 4'h4, 0, 16'h0041);
      outs(5'h05);
      bus(1, 4'h8, 16'h0001, 0);
      outs(5'h07);
      $display("t_amp done");
   endtask
   task automatic t_cmp;
      bus(1, 4'h0, 16'h0003, 0);
      lp <= 16'h1080; ln <= 16'h2040;
      repeat (4) @(posedge clk);
      bus(0, 4'h4, 0, 16'h0841);
      bus(0, 4'h8, 0, 16'h0001);
      lp <= 16'h2040; ln <= 16'h1080;
      repeat (4) @(posedge clk);
      bus(0, 4'h4, 0, 16'h0041);
      bus(0, 4'h8, 0, 16'h0801);
      bus(1, 4'h0, 16'h0001, 0);
      bus(0, 4'h8, 0, 16'h0001);
      bus(1, 4'h0, 16'h0000, 0);
      outs(5'h00);
      $display("t_cmp done");
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst <= 0;
      t_reset;
      t_amp;
      t_cmp;
      close_out;
   end
   // run needs well under 1000 cycles
   initial begin
      #20us;
      n_errors++;
      close_out;
   end
endmodule
`default_nettype wire
